// ==== rtl/lane_pkg.sv ====
// Purpose: shared constants for the serial lane control block
// Assumes: 32-bit APB register words, byte offsets
// Notes: register offsets and field layouts of the lane configuration
package lane_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int INT_W = 10;
	localparam int STEP_W = 12;
	localparam int ACC_W = 12;

	// register byte offsets
	localparam logic [ADDR_W-1:0] LOOP_CFG_OFS = 8'h00;
	localparam logic [ADDR_W-1:0] RATE_CFG_OFS = 8'h04;
	localparam logic [ADDR_W-1:0] BUF_CFG_OFS = 8'h08;
	localparam logic [ADDR_W-1:0] TAP_CFG_OFS = 8'h0C;
	localparam logic [ADDR_W-1:0] MISC_CFG_OFS = 8'h10;
	localparam logic [ADDR_W-1:0] LOOP_STAT_OFS = 8'h14;
	localparam logic [ADDR_W-1:0] TAP_STAT_OFS = 8'h18;

	// loop_cfg fields
	localparam int LIMIT_LSB = 0;
	localparam int TCONST_LSB = 4;
	localparam int BW_LSB = 8;
	localparam int DLOCK_BIT = 12;
	// rate_cfg fields
	localparam int HALF_RATE_SEL_BIT = 0;
	localparam int QUARTER_RATE_SEL_BIT = 1;
	localparam int FLOOP_BIT = 2;
	localparam int ALIGN_BIT = 3;
	localparam int OSPD_BIT = 4;
	localparam int PDSEL_LSB = 8;
	// buf_cfg fields
	localparam int FXMODE_BIT = 0;
	localparam int OFFS_BIT = 1;
	localparam int LOWSUP_BIT = 2;
	localparam int SKEW_BIT = 3;
	// tap_cfg fields
	localparam int PREC_LSB = 0;
	localparam int POST0_LSB = 8;
	localparam int POST1_LSB = 16;
	localparam int POL_BIT = 21;
	localparam int LEV_LSB = 24;
	// misc_cfg fields
	localparam int TXLPI_BIT = 0;
	localparam int RXLPI_BIT = 1;
	localparam int TXINV_BIT = 2;
	localparam int RXINV_BIT = 3;
	// loop_stat fields
	localparam int STEP_LSB = 16;
	// tap_stat fields
	localparam int C1_LSB = 0;
	localparam int C1POL_BIT = 6;
	localparam int K_LSB = 8;

	// reset values
	localparam logic [2:0] LIMIT_RST = 3'h3;
	localparam logic [2:0] TCONST_RST = 3'h5;
	localparam logic [2:0] BW_RST = 3'h4;
	localparam logic [1:0] PDSEL_RST = 2'h0;
	localparam logic POL_RST = 1'b1;
	localparam logic OFFS_RST = 1'b1;
	localparam logic LOWSUP_RST = 1'b0;

	// coefficient arithmetic
	localparam logic [6:0] CENTRE_BASE = 7'h40;
	localparam logic [6:0] AMP_BASE = 7'h40;
	localparam logic [7:0] PROP_MAX = 8'h80;
	localparam logic [STEP_W-1:0] DLOCK_OFS = 12'h001;
endpackage : lane_pkg

// ==== rtl/phase_regulator.sv ====
// Purpose: proportional-plus-integral phase loop of the receive clock recovery
// Assumes: early/late votes already synchronised, one per cycle at most
// Notes: integrator limit is always held below the proportional step
`timescale 1ns/100ps
module phase_regulator import lane_pkg::*; (
	input wire logic clk, // lane clock
	input wire logic rst_n, // async reset, active low
	input wire logic early, // sample point early
	input wire logic late, // sample point late
	input wire logic [2:0] limit_cfg, // integrator limit exponent
	input wire logic [2:0] time_const, // integrator time constant
	input wire logic [2:0] bandwidth, // proportional bandwidth setting
	input wire logic dlock_ena, // deadlock protection
	output logic signed [INT_W-1:0] integ, // integrator value
	output logic signed [STEP_W-1:0] step // phase correction
);
	logic signed [ACC_W-1:0] acc_r, acc_nxt;
	logic signed [INT_W-1:0] integ_r, integ_nxt;
	logic signed [STEP_W-1:0] step_r, step_nxt;
	logic [3:0] shift;
	logic signed [ACC_W-1:0] thr;
	logic signed [STEP_W-1:0] prop;
	logic signed [INT_W-1:0] lim;

	always_comb begin
		// integration rate follows 2^(time_const+1-bw), clamped at one vote
		shift = ({1'b0, time_const} + 4'h1 > {1'b0, bandwidth}) ?
			4'({1'b0, time_const} + 4'h1 - {1'b0, bandwidth}) : 4'h0;
		thr = ACC_W'(1) <<< shift;
		prop = STEP_W'(PROP_MAX >> bandwidth);
		lim = INT_W'(1) <<< limit_cfg;
		if (STEP_W'(lim) >= prop)
			lim = INT_W'(prop - STEP_W'(1));
		acc_nxt = acc_r + (late ? ACC_W'(1) : ACC_W'(0)) - (early ? ACC_W'(1) : ACC_W'(0));
		integ_nxt = integ_r;
		if (acc_nxt >= thr) begin
			acc_nxt = '0;
			if (integ_r < lim)
				integ_nxt = integ_r + INT_W'(1);
		end else if (acc_nxt <= -thr) begin
			acc_nxt = '0;
			if (integ_r > -lim)
				integ_nxt = integ_r - INT_W'(1);
		end
		if (integ_nxt > lim)
			integ_nxt = lim;
		else if (integ_nxt < -lim)
			integ_nxt = -lim;
		step_nxt = STEP_W'(integ_r);
		if (late && !early)
			step_nxt = step_nxt + prop;
		else if (early && !late)
			step_nxt = step_nxt - prop;
		if (dlock_ena)
			step_nxt = step_nxt + DLOCK_OFS;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_r <= '0;
			integ_r <= '0;
			step_r <= '0;
		end else begin
			acc_r <= acc_nxt;
			integ_r <= integ_nxt;
			step_r <= step_nxt;
		end
	end

	assign integ = integ_r;
	assign step = step_r;
endmodule : phase_regulator

// ==== rtl/tap_encoder.sv ====
// Purpose: derives centre tap and amplitude coefficient of the output driver
// Assumes: tap fields are sign-magnitude with polarity in the top bit
// Notes: purely combinational, follows the held fields at once
`timescale 1ns/100ps
module tap_encoder import lane_pkg::*; (
	input wire logic [4:0] pre_cursor, // pre-cursor tap
	input wire logic [5:0] first_post, // first post-cursor tap
	input wire logic [4:0] second_post, // second post-cursor tap
	input wire logic [5:0] level, // amplitude level
	output logic [5:0] c1_mag, // centre tap magnitude
	output logic [6:0] amp_k // amplitude coefficient
);
	logic [6:0] sum;
	logic [6:0] diff;

	always_comb begin
		sum = 7'(pre_cursor[3:0]) + 7'(first_post[4:0]) + 7'(second_post[3:0]);
		diff = CENTRE_BASE - sum;
		// 64 itself does not fit six bits, saturate instead of wrapping to zero
		c1_mag = diff[6] ? 6'h3F : diff[5:0];
		amp_k = AMP_BASE + 7'(level);
	end
endmodule : tap_encoder

// ==== rtl/lane_ctrl.sv ====
// Purpose: digital control and configuration of one multi-rate serial lane
// Assumes: single clock pclk, APB register access, analog votes arrive async
// Notes: all outputs registered; registers hold until software rewrites them
//
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
module lane_ctrl import lane_pkg::*; #(
	parameter int DW = 10 // parallel data width
) (
	input wire logic pclk, // clock, 10 MHz
	input wire logic presetn, // async reset, active low
	input wire logic [ADDR_W-1:0] paddr, // APB address
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB write
	input wire logic [DATA_W-1:0] pwdata, // APB write data
	output logic [DATA_W-1:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error, unmapped address
	input wire logic rx_early, // analog sampler early vote
	input wire logic rx_late, // analog sampler late vote
	input wire logic [DW-1:0] tx_data_in, // transmit word from PCS
	input wire logic [DW-1:0] rx_data_in, // receive word from deserializer
	input wire logic pcs_tx_active, // PCS wants output buffer on
	input wire logic pcs_rx_active, // PCS wants input buffer on
	output logic [DW-1:0] tx_data_out, // transmit word to serializer
	output logic [DW-1:0] rx_data_out, // receive word to PCS
	output logic [STEP_W-1:0] phase_step, // phase correction to interpolator
	output logic ser_align, // serializer phase alignment active
	output logic fx_mode, // input buffer 100BASE-FX mode
	output logic offset_comp, // input offset compensation enable
	output logic low_supply, // output buffer 1.0 V mode
	output logic ospd_ena, // oversampling detector enable
	output logic [1:0] pd_select, // phase detector select
	output logic [4:0] c0, // pre-cursor coefficient
	output logic [5:0] c1, // centre tap magnitude
	output logic c1_pol, // centre tap polarity
	output logic [5:0] c2, // first post-cursor coefficient
	output logic [4:0] c3, // second post-cursor coefficient
	output logic [6:0] amp_k, // amplitude coefficient
	output logic skew_ena, // effective skew adjustment
	output logic ob_active, // output buffer active
	output logic ib_active // input buffer active
);
	// configuration fields
	logic [2:0] integrator_limit_cfg_r, integrator_limit_cfg_nxt;
	logic [2:0] integrator_time_const_r, integrator_time_const_nxt;
	logic [2:0] prop_loop_bandwidth_r, prop_loop_bandwidth_nxt;
	logic deadlock_protect_cfg_r, deadlock_protect_cfg_nxt;
	logic half_rate_sel_r, half_rate_sel_nxt;
	logic quarter_rate_sel_r, quarter_rate_sel_nxt;
	logic floop_ena_r, floop_ena_nxt;
	logic tx_phase_align_ena_r, tx_phase_align_ena_nxt;
	logic oversample_detector_ena_r, oversample_detector_ena_nxt;
	logic [1:0] phase_detector_select_r, phase_detector_select_nxt;
	logic rx_buffer_fx_mode_r, rx_buffer_fx_mode_nxt;
	logic rx_offset_comp_ena_r, rx_offset_comp_ena_nxt;
	logic tx_low_supply_mode_r, tx_low_supply_mode_nxt;
	logic tx_skew_adjust_r, tx_skew_adjust_nxt;
	logic [4:0] tap_pre_cursor_r, tap_pre_cursor_nxt;
	logic [5:0] tap_first_post_r, tap_first_post_nxt;
	logic [4:0] tap_second_post_r, tap_second_post_nxt;
	logic centre_tap_polarity_r, centre_tap_polarity_nxt;
	logic [5:0] tx_amplitude_level_r, tx_amplitude_level_nxt;
	logic tx_low_power_idle_ena_r, tx_low_power_idle_ena_nxt;
	logic rx_low_power_idle_ena_r, rx_low_power_idle_ena_nxt;
	logic tx_invert_ena_r, tx_invert_ena_nxt;
	logic rx_invert_ena_r, rx_invert_ena_nxt;
	// bus answer
	logic [DATA_W-1:0] prdata_r, prdata_nxt;
	logic pready_r, pready_nxt;
	logic pslverr_r, pslverr_nxt;
	// vote synchronisers
	logic [1:0] early_sync_r, late_sync_r;
	// registered outputs
	logic [DW-1:0] tx_data_r, tx_data_nxt;
	logic [DW-1:0] rx_data_r, rx_data_nxt;
	logic ser_align_r, ser_align_nxt;
	logic [5:0] c1_r, c1_nxt;
	logic [6:0] amp_k_r, amp_k_nxt;
	logic skew_ena_r, skew_ena_nxt;
	logic ob_active_r, ob_active_nxt;
	logic ib_active_r, ib_active_nxt;
	// derived values
	logic signed [INT_W-1:0] integ;
	logic signed [STEP_W-1:0] step;
	logic [5:0] c1_mag;
	logic [6:0] k_val;
	logic setup;
	logic lpi_handover;

	phase_regulator u_phase_regulator (
		.clk(pclk),
		.rst_n(presetn),
		.early(early_sync_r[1]),
		.late(late_sync_r[1]),
		.limit_cfg(integrator_limit_cfg_r),
		.time_const(integrator_time_const_r),
		.bandwidth(prop_loop_bandwidth_r),
		.dlock_ena(deadlock_protect_cfg_r),
		.integ(integ),
		.step(step)
	);

	tap_encoder u_tap_encoder (
		.pre_cursor(tap_pre_cursor_r),
		.first_post(tap_first_post_r),
		.second_post(tap_second_post_r),
		.level(tx_amplitude_level_r),
		.c1_mag(c1_mag),
		.amp_k(k_val)
	);

	// register writes, taken in the setup cycle, answered one cycle later
	always_comb begin
		setup = psel && !penable;
		integrator_limit_cfg_nxt = integrator_limit_cfg_r;
		integrator_time_const_nxt = integrator_time_const_r;
		prop_loop_bandwidth_nxt = prop_loop_bandwidth_r;
		deadlock_protect_cfg_nxt = deadlock_protect_cfg_r;
		half_rate_sel_nxt = half_rate_sel_r;
		quarter_rate_sel_nxt = quarter_rate_sel_r;
		floop_ena_nxt = floop_ena_r;
		tx_phase_align_ena_nxt = tx_phase_align_ena_r;
		oversample_detector_ena_nxt = oversample_detector_ena_r;
		phase_detector_select_nxt = phase_detector_select_r;
		rx_buffer_fx_mode_nxt = rx_buffer_fx_mode_r;
		rx_offset_comp_ena_nxt = rx_offset_comp_ena_r;
		tx_low_supply_mode_nxt = tx_low_supply_mode_r;
		tx_skew_adjust_nxt = tx_skew_adjust_r;
		tap_pre_cursor_nxt = tap_pre_cursor_r;
		tap_first_post_nxt = tap_first_post_r;
		tap_second_post_nxt = tap_second_post_r;
		centre_tap_polarity_nxt = centre_tap_polarity_r;
		tx_amplitude_level_nxt = tx_amplitude_level_r;
		tx_low_power_idle_ena_nxt = tx_low_power_idle_ena_r;
		rx_low_power_idle_ena_nxt = rx_low_power_idle_ena_r;
		tx_invert_ena_nxt = tx_invert_ena_r;
		rx_invert_ena_nxt = rx_invert_ena_r;
		prdata_nxt = '0;
		pready_nxt = setup;
		pslverr_nxt = 1'b0;
		if (setup) begin
			unique case (paddr)
				LOOP_CFG_OFS: begin
					if (pwrite) begin
						integrator_limit_cfg_nxt = pwdata[LIMIT_LSB +: 3];
						integrator_time_const_nxt = pwdata[TCONST_LSB +: 3];
						prop_loop_bandwidth_nxt = pwdata[BW_LSB +: 3];
						deadlock_protect_cfg_nxt = pwdata[DLOCK_BIT];
					end
					prdata_nxt[LIMIT_LSB +: 3] = integrator_limit_cfg_r;
					prdata_nxt[TCONST_LSB +: 3] = integrator_time_const_r;
					prdata_nxt[BW_LSB +: 3] = prop_loop_bandwidth_r;
					prdata_nxt[DLOCK_BIT] = deadlock_protect_cfg_r;
				end
				RATE_CFG_OFS: begin
					if (pwrite) begin
						half_rate_sel_nxt = pwdata[HALF_RATE_SEL_BIT];
						quarter_rate_sel_nxt = pwdata[QUARTER_RATE_SEL_BIT];
						floop_ena_nxt = pwdata[FLOOP_BIT];
						tx_phase_align_ena_nxt = pwdata[ALIGN_BIT];
						oversample_detector_ena_nxt = pwdata[OSPD_BIT];
						phase_detector_select_nxt = pwdata[PDSEL_LSB +: 2];
					end
					prdata_nxt[HALF_RATE_SEL_BIT] = half_rate_sel_r;
					prdata_nxt[QUARTER_RATE_SEL_BIT] = quarter_rate_sel_r;
					prdata_nxt[FLOOP_BIT] = floop_ena_r;
					prdata_nxt[ALIGN_BIT] = tx_phase_align_ena_r;
					prdata_nxt[OSPD_BIT] = oversample_detector_ena_r;
					prdata_nxt[PDSEL_LSB +: 2] = phase_detector_select_r;
				end
				BUF_CFG_OFS: begin
					if (pwrite) begin
						rx_buffer_fx_mode_nxt = pwdata[FXMODE_BIT];
						rx_offset_comp_ena_nxt = pwdata[OFFS_BIT];
						tx_low_supply_mode_nxt = pwdata[LOWSUP_BIT];
						tx_skew_adjust_nxt = pwdata[SKEW_BIT];
					end
					prdata_nxt[FXMODE_BIT] = rx_buffer_fx_mode_r;
					prdata_nxt[OFFS_BIT] = rx_offset_comp_ena_r;
					prdata_nxt[LOWSUP_BIT] = tx_low_supply_mode_r;
					prdata_nxt[SKEW_BIT] = tx_skew_adjust_r;
				end
				TAP_CFG_OFS: begin
					if (pwrite) begin
						tap_pre_cursor_nxt = pwdata[PREC_LSB +: 5];
						tap_first_post_nxt = pwdata[POST0_LSB +: 6];
						tap_second_post_nxt = pwdata[POST1_LSB +: 5];
						centre_tap_polarity_nxt = pwdata[POL_BIT];
						tx_amplitude_level_nxt = pwdata[LEV_LSB +: 6];
					end
					prdata_nxt[PREC_LSB +: 5] = tap_pre_cursor_r;
					prdata_nxt[POST0_LSB +: 6] = tap_first_post_r;
					prdata_nxt[POST1_LSB +: 5] = tap_second_post_r;
					prdata_nxt[POL_BIT] = centre_tap_polarity_r;
					prdata_nxt[LEV_LSB +: 6] = tx_amplitude_level_r;
				end
				MISC_CFG_OFS: begin
					if (pwrite) begin
						tx_low_power_idle_ena_nxt = pwdata[TXLPI_BIT];
						rx_low_power_idle_ena_nxt = pwdata[RXLPI_BIT];
						tx_invert_ena_nxt = pwdata[TXINV_BIT];
						rx_invert_ena_nxt = pwdata[RXINV_BIT];
					end
					prdata_nxt[TXLPI_BIT] = tx_low_power_idle_ena_r;
					prdata_nxt[RXLPI_BIT] = rx_low_power_idle_ena_r;
					prdata_nxt[TXINV_BIT] = tx_invert_ena_r;
					prdata_nxt[RXINV_BIT] = rx_invert_ena_r;
				end
				LOOP_STAT_OFS: begin
					// read-only view of the loop; writes are ignored
					prdata_nxt[INT_W-1:0] = integ;
					prdata_nxt[STEP_LSB +: STEP_W] = step;
				end
				TAP_STAT_OFS: begin
					prdata_nxt[C1_LSB +: 6] = c1_r;
					prdata_nxt[C1POL_BIT] = centre_tap_polarity_r;
					prdata_nxt[K_LSB +: 7] = amp_k_r;
				end
				default: pslverr_nxt = 1'b1;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			integrator_limit_cfg_r <= LIMIT_RST;
			integrator_time_const_r <= TCONST_RST;
			prop_loop_bandwidth_r <= BW_RST;
			deadlock_protect_cfg_r <= 1'b0;
			half_rate_sel_r <= 1'b0;
			quarter_rate_sel_r <= 1'b0;
			floop_ena_r <= 1'b0;
			tx_phase_align_ena_r <= 1'b0;
			oversample_detector_ena_r <= 1'b0;
			phase_detector_select_r <= PDSEL_RST;
			rx_buffer_fx_mode_r <= 1'b0;
			rx_offset_comp_ena_r <= OFFS_RST;
			tx_low_supply_mode_r <= LOWSUP_RST;
			tx_skew_adjust_r <= 1'b0;
			tap_pre_cursor_r <= '0;
			tap_first_post_r <= '0;
			tap_second_post_r <= '0;
			centre_tap_polarity_r <= POL_RST;
			tx_amplitude_level_r <= '0;
			tx_low_power_idle_ena_r <= 1'b0;
			rx_low_power_idle_ena_r <= 1'b0;
			tx_invert_ena_r <= 1'b0;
			rx_invert_ena_r <= 1'b0;
			prdata_r <= '0;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end else begin
			integrator_limit_cfg_r <= integrator_limit_cfg_nxt;
			integrator_time_const_r <= integrator_time_const_nxt;
			prop_loop_bandwidth_r <= prop_loop_bandwidth_nxt;
			deadlock_protect_cfg_r <= deadlock_protect_cfg_nxt;
			half_rate_sel_r <= half_rate_sel_nxt;
			quarter_rate_sel_r <= quarter_rate_sel_nxt;
			floop_ena_r <= floop_ena_nxt;
			tx_phase_align_ena_r <= tx_phase_align_ena_nxt;
			oversample_detector_ena_r <= oversample_detector_ena_nxt;
			phase_detector_select_r <= phase_detector_select_nxt;
			rx_buffer_fx_mode_r <= rx_buffer_fx_mode_nxt;
			rx_offset_comp_ena_r <= rx_offset_comp_ena_nxt;
			tx_low_supply_mode_r <= tx_low_supply_mode_nxt;
			tx_skew_adjust_r <= tx_skew_adjust_nxt;
			tap_pre_cursor_r <= tap_pre_cursor_nxt;
			tap_first_post_r <= tap_first_post_nxt;
			tap_second_post_r <= tap_second_post_nxt;
			centre_tap_polarity_r <= centre_tap_polarity_nxt;
			tx_amplitude_level_r <= tx_amplitude_level_nxt;
			tx_low_power_idle_ena_r <= tx_low_power_idle_ena_nxt;
			rx_low_power_idle_ena_r <= rx_low_power_idle_ena_nxt;
			tx_invert_ena_r <= tx_invert_ena_nxt;
			rx_invert_ena_r <= rx_invert_ena_nxt;
			prdata_r <= prdata_nxt;
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	// datapath and buffer control, one cycle behind the held fields
	always_comb begin
		lpi_handover = tx_low_power_idle_ena_r && rx_low_power_idle_ena_r;
		tx_data_nxt = tx_invert_ena_r ? ~tx_data_in : tx_data_in;
		rx_data_nxt = rx_invert_ena_r ? ~rx_data_in : rx_data_in;
		ser_align_nxt = tx_phase_align_ena_r && floop_ena_r;
		c1_nxt = c1_mag;
		amp_k_nxt = k_val;
		// 1 Gbps is the quarter-rate setting; no skew in any other mode
		skew_ena_nxt = tx_skew_adjust_r && quarter_rate_sel_r && !half_rate_sel_r;
		ob_active_nxt = lpi_handover ? pcs_tx_active : 1'b1;
		ib_active_nxt = lpi_handover ? pcs_rx_active : 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			early_sync_r <= '0;
			late_sync_r <= '0;
			tx_data_r <= '0;
			rx_data_r <= '0;
			ser_align_r <= 1'b0;
			c1_r <= '0;
			amp_k_r <= AMP_BASE;
			skew_ena_r <= 1'b0;
			ob_active_r <= 1'b1;
			ib_active_r <= 1'b1;
		end else begin
			early_sync_r <= {early_sync_r[0], rx_early};
			late_sync_r <= {late_sync_r[0], rx_late};
			tx_data_r <= tx_data_nxt;
			rx_data_r <= rx_data_nxt;
			ser_align_r <= ser_align_nxt;
			c1_r <= c1_nxt;
			amp_k_r <= amp_k_nxt;
			skew_ena_r <= skew_ena_nxt;
			ob_active_r <= ob_active_nxt;
			ib_active_r <= ib_active_nxt;
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign tx_data_out = tx_data_r;
	assign rx_data_out = rx_data_r;
	assign phase_step = step;
	assign ser_align = ser_align_r;
	assign fx_mode = rx_buffer_fx_mode_r;
	assign offset_comp = rx_offset_comp_ena_r;
	assign low_supply = tx_low_supply_mode_r;
	assign ospd_ena = oversample_detector_ena_r;
	assign pd_select = phase_detector_select_r;
	assign c0 = tap_pre_cursor_r;
	assign c1 = c1_r;
	assign c1_pol = centre_tap_polarity_r;
	assign c2 = tap_first_post_r;
	assign c3 = tap_second_post_r;
	assign amp_k = amp_k_r;
	assign skew_ena = skew_ena_r;
	assign ob_active = ob_active_r;
	assign ib_active = ib_active_r;
endmodule : lane_ctrl

// ==== verif/lane_link_partner.sv ====
// Purpose: remote link partner, sampler votes and received words
// Assumes: bench clock, changes just after each rising edge
// Notes: both vote lines low means no vote
`timescale 1ns/100ps
module lane_link_partner (
	input wire logic clk, // lane clock
	input wire logic [1:0] vote_sel, // bit0 late, bit1 early
	input wire logic [9:0] word, // word to send
	output logic early, // early vote
	output logic late, // late vote
	output logic [9:0] rx_word // received word
);
	initial begin
		early = 1'b0;
		late = 1'b0;
		rx_word = 10'h000;
	end
	always @(posedge clk) begin
		late <= vote_sel[0];
		early <= vote_sel[1];
		rx_word <= word;
	end
endmodule : lane_link_partner

// ==== verif/lane_ctrl_monitor.sv ====
// Purpose: port checker for the lane control block
// Assumes: single clock, zero-wait APB slave
// Notes: bound to every lane_ctrl instance
`timescale 1ns/100ps
module lane_ctrl_monitor import lane_pkg::*; #(
	parameter int DW = 10 // word width
) (
	input wire logic pclk, // clock
	input wire logic presetn, // reset
	input wire logic [ADDR_W-1:0] paddr, // apb
	input wire logic psel, // apb
	input wire logic penable, // apb
	input wire logic pwrite, // apb
	input wire logic [DATA_W-1:0] pwdata, // apb
	input wire logic [DATA_W-1:0] prdata, // apb
	input wire logic pready, // apb
	input wire logic pslverr, // apb
	input wire logic [DW-1:0] tx_data_in, // tx word in
	input wire logic [DW-1:0] tx_data_out, // tx word out
	input wire logic pcs_tx_active, // pcs request
	input wire logic pcs_rx_active, // pcs request
	input wire logic ob_active, // output buffer
	input wire logic ib_active, // input buffer
	input wire logic [4:0] c0, // taps
	input wire logic [5:0] c1, // taps
	input wire logic [5:0] c2, // taps
	input wire logic [4:0] c3, // taps
	input wire logic [6:0] amp_k // amplitude
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic warm_r;
	logic [5:0] c1_r;
	logic [5:0] c1_nxt;
	logic [5:0] lev_r;
	logic [6:0] diff;
	always_comb begin
		diff = 7'h40 - (7'(c0[3:0]) + 7'(c2[4:0]) + 7'(c3[3:0]));
		// 64 cannot be held in six bits
		c1_nxt = diff[6] ? 6'h3F : diff[5:0];
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			warm_r <= 1'b0;
			c1_r <= 6'h00;
			lev_r <= 6'h00;
		end else begin
			warm_r <= 1'b1;
			c1_r <= c1_nxt;
			lev_r <= (psel && !penable && pwrite && paddr == TAP_CFG_OFS) ? pwdata[29:24] : lev_r;
		end
	end
	a_ready_after_setup: assert property (psel && !penable |=> pready && psel && penable)
		else $error("no ready after setup");
	a_ready_one_cycle: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	a_error_unmapped: assert property (psel && !penable && paddr > 8'h18 |=> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	a_centre_tap_sum: assert property (warm_r |-> c1 == c1_r)
		else $error("centre tap mismatch");
	a_amp_from_level: assert property (psel && !penable && pwrite && paddr == TAP_CFG_OFS |=> ##1 amp_k == {1'b1, lev_r})
		else $error("amplitude coefficient mismatch");
	a_tx_word_invert: assert property (warm_r |-> (&(tx_data_out ^ $past(tx_data_in))) || !(|(tx_data_out ^ $past(tx_data_in))))
		else $error("tx word neither copied nor inverted");
	a_tx_handover: assert property (!ob_active |-> !$past(pcs_tx_active))
		else $error("output buffer off without pcs");
	a_rx_handover: assert property (!ib_active |-> !$past(pcs_rx_active))
		else $error("input buffer off without pcs");
endmodule : lane_ctrl_monitor
bind lane_ctrl lane_ctrl_monitor #(.DW(DW)) mon (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
	.pready, .pslverr, .tx_data_in, .tx_data_out, .pcs_tx_active, .pcs_rx_active, .ob_active, .ib_active,
	.c0, .c1, .c2, .c3, .amp_k);

// ==== verif/serdes_lane_digital_control_test.sv ====
// Purpose: self-checking bench of the lane control block
// Assumes: APB slave answers in its own time, partner model on the link side
// Notes: reset values and loop_cfg read first, then tap rows, then hand cases
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin mismatches++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module serdes_lane_digital_control_test import lane_pkg::*;;
	typedef struct packed {logic [31:0] w; logic [5:0] c1; logic pol; logic [6:0] k;} tap_row_t;
	localparam tap_row_t ROWS [3] = '{'{32'h00230A05, 6'h2E, 1'b1, 7'h40}, '{32'h3F1F3F1F, 6'h03, 1'b0, 7'h7F},
		'{32'h01200000, 6'h3F, 1'b1, 7'h41}};
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic pready, pslverr, e, rx_early, rx_late, ser_align, fx_mode, offset_comp, low_supply, ospd_ena;
	logic c1_pol, skew_ena, ob_active, ib_active, pcs_tx_active = 1'b0, pcs_rx_active = 1'b1;
	logic [1:0] pd_select, vote = 2'b00;
	logic [4:0] c0, c3;
	logic [5:0] c1, c2;
	logic [6:0] amp_k;
	logic [11:0] phase_step;
	logic [9:0] tx_data_in = 10'h000, rx_data_in, tx_data_out, rx_data_out, word = 10'h0F0;
	int mismatches = 0, checks_done = 0;
	always #50 pclk = ~pclk;
	lane_ctrl #(.DW(10)) dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
		.rx_early, .rx_late, .tx_data_in, .rx_data_in, .pcs_tx_active, .pcs_rx_active, .tx_data_out, .rx_data_out,
		.phase_step, .ser_align, .fx_mode, .offset_comp, .low_supply, .ospd_ena, .pd_select, .c0, .c1, .c1_pol,
		.c2, .c3, .amp_k, .skew_ena, .ob_active, .ib_active);
	lane_link_partner peer (.clk(pclk), .vote_sel(vote), .word(word), .early(rx_early), .late(rx_late),
		.rx_word(rx_data_in));
	task close_out;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : close_out
	// ends on a falling edge so registered outputs have settled
	task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 20) begin n++; @(posedge pclk); end
		if (pready !== 1'b1) begin mismatches++; close_out(); end
		q = prdata;
		e = pslverr;
		psel <= 1'b0; penable <= 1'b0;
		@(negedge pclk);
	endtask : apb
	task pulse(input logic [1:0] v, input logic [11:0] x);
		int n;
		n = 0;
		@(posedge pclk); vote <= v;
		@(posedge pclk); vote <= 2'b00;
		@(negedge pclk);
		while (phase_step === 12'h000 && n < 8) begin n++; @(negedge pclk); end
		`CHK("phase_step", x, phase_step)
	endtask : pulse
	initial begin
		#2000000 mismatches++;
		close_out();
	end
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(negedge pclk);
		`CHK("low_supply", 1'b0, low_supply)
		`CHK("c1_pol", 1'b1, c1_pol)
		`CHK("amp_k", 7'h40, amp_k)
		apb(LOOP_CFG_OFS, 1'b0, 32'h0);
		`CHK("loop_cfg", 32'h00000453, q)
		for (int i = 0; i < 3; i++) begin
			apb(TAP_CFG_OFS, 1'b1, ROWS[i].w);
			apb(TAP_CFG_OFS, 1'b0, 32'h0);
			`CHK("tap_cfg", ROWS[i].w, q)
			`CHK("c0", ROWS[i].w[4:0], c0)
			`CHK("c2", ROWS[i].w[13:8], c2)
			`CHK("c3", ROWS[i].w[20:16], c3)
			`CHK("c1", ROWS[i].c1, c1)
			`CHK("c1_pol", ROWS[i].pol, c1_pol)
			`CHK("amp_k", ROWS[i].k, amp_k)
		end
		apb(8'h40, 1'b0, 32'h0);
		`CHK("pslverr", 1'b1, e)
		`CHK("prdata", 32'h0, q)
		apb(BUF_CFG_OFS, 1'b1, 32'hD);
		`CHK("fx_mode", 1'b1, fx_mode)
		`CHK("offset_comp", 1'b0, offset_comp)
		`CHK("low_supply", 1'b1, low_supply)
		`CHK("skew_ena", 1'b0, skew_ena)
		apb(RATE_CFG_OFS, 1'b1, 32'h21E);
		`CHK("ser_align", 1'b1, ser_align)
		`CHK("skew_ena", 1'b1, skew_ena)
		`CHK("pd_select", 2'h2, pd_select)
		`CHK("ospd_ena", 1'b1, ospd_ena)
		apb(RATE_CFG_OFS, 1'b1, 32'h00B);
		`CHK("ser_align", 1'b0, ser_align)
		`CHK("skew_ena", 1'b0, skew_ena)
		apb(LOOP_CFG_OFS, 1'b1, 32'h1453);
		`CHK("phase_step", 12'h001, phase_step)
		apb(LOOP_CFG_OFS, 1'b1, 32'h0353);
		pulse(2'b11, 12'h000);
		pulse(2'b01, 12'h010);
		apb(LOOP_CFG_OFS, 1'b1, 32'h0453);
		pulse(2'b10, 12'hFF8);
		@(posedge pclk) tx_data_in <= 10'h2A5;
		apb(MISC_CFG_OFS, 1'b1, 32'h4);
		`CHK("tx_data_out", 10'h15A, tx_data_out)
		`CHK("rx_data_out", 10'h0F0, rx_data_out)
		apb(MISC_CFG_OFS, 1'b1, 32'h8);
		`CHK("tx_data_out", 10'h2A5, tx_data_out)
		`CHK("rx_data_out", 10'h30F, rx_data_out)
		apb(MISC_CFG_OFS, 1'b1, 32'h1);
		`CHK("ob_active", 1'b1, ob_active)
		apb(MISC_CFG_OFS, 1'b1, 32'h3);
		`CHK("ob_active", 1'b0, ob_active)
		`CHK("ib_active", 1'b1, ib_active)
		@(posedge pclk) pcs_tx_active <= 1'b1;
		pcs_rx_active <= 1'b0;
		repeat (2) @(negedge pclk);
		`CHK("ob_active", 1'b1, ob_active)
		`CHK("ib_active", 1'b0, ib_active)
		@(posedge pclk) presetn <= 1'b0;
		@(negedge pclk);
		`CHK("low_supply", 1'b0, low_supply)
		`CHK("ib_active", 1'b1, ib_active)
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(MISC_CFG_OFS, 1'b0, 32'h0);
		`CHK("misc_cfg", 32'h0, q)
		close_out();
	end
endmodule : serdes_lane_digital_control_test
